// *** tpse_pkg.sv ***
// Purpose: Shared constants and types for the ternary PCS transmit block
// Assumes: 40 MHz mclk, one triplet per symbol-group tick
// Notes:   Symbols are 2-bit two's complement: +1, 0, -1
package tpse_pkg;

  localparam int         MCLK_NS   = 25;
  localparam int         TRIP_NS   = 400;
  localparam int         TRIP_CYC  = (TRIP_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [4:0] TRIP_LAST = 5'(TRIP_CYC - 1);

  localparam int         AW       = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_SCR  = 4'h8;

  localparam int         CB_MASTER  = 0;
  localparam int         CB_RCVR_OK = 1;
  localparam int         CB_LPI     = 2;
  localparam int         CB_SRST    = 3;
  localparam logic [2:0] CTRL_RST   = 3'h1;

  localparam int          SB_SCR_TOP = 8;
  localparam logic [32:0] SCR_SEED   = 33'h1A5A5A5A5;
  localparam int          TAP_M      = 12;
  localparam int          TAP_S      = 19;
  localparam int          TAP_TOP    = 32;

  localparam logic [2:0] DISP_INIT = 3'h2;
  localparam logic [2:0] DISP_RES  = 3'h1;
  localparam logic [2:0] DISP_MAX  = 3'h4;

  localparam logic [1:0] SYM_P = 2'h1;
  localparam logic [1:0] SYM_Z = 2'h0;
  localparam logic [1:0] SYM_N = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    K_NORM  = 3'h0,
    K_COMMA = 3'h1,
    K_DRES  = 3'h2,
    K_SSD4  = 3'h3,
    K_ESD4  = 3'h4,
    K_EERR  = 3'h5,
    K_SENDZ = 3'h6
  } tpse_kind_t;

  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] c;
  } tpse_trip_t;

  typedef struct packed {
    logic lpi_req;
    logic rcvr_ok;
    logic master;
  } tpse_ctrl_t;

endpackage

// *** tpse_tx.sv ***
// Purpose: Side-stream scrambler, 4B3T encoder and delimiter triplets
// Assumes: MAC nibble and tx_kind are on mclk; AXI4-Lite on mclk
// Notes:   One nibble becomes one triplet on each K_NORM group tick with mii_tx_en high
`timescale 1ns/1ps

module tpse_tx (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [tpse_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [tpse_pkg::AW-1:0] s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  input  wire logic                   mii_tx_en,
  input  wire logic [3:0]             mii_txd,
  input  wire tpse_pkg::tpse_kind_t   tx_kind,
  output tpse_pkg::tpse_trip_t        trip_out,
  output logic                        trip_valid,
  output logic                        nibble_taken
);
  import tpse_pkg::*;

  // Bus state
  logic                awready_reg, awready_next;
  logic                wready_reg,  wready_next;
  logic                aw_full_reg, aw_full_next;
  logic                w_full_reg,  w_full_next;
  logic [AW-1:0]       awaddr_reg,  awaddr_next;
  logic [31:0]         wdata_reg,   wdata_next;
  logic [3:0]          wstrb_reg,   wstrb_next;
  logic                bvalid_reg,  bvalid_next;
  logic [1:0]          bresp_reg,   bresp_next;
  logic                arready_reg, arready_next;
  logic                rvalid_reg,  rvalid_next;
  logic [31:0]         rdata_reg,   rdata_next;
  logic [1:0]          rresp_reg,   rresp_next;
  tpse_ctrl_t          ctrl_reg,    ctrl_next;
  logic                srst_reg,    srst_next;

  // Core state
  logic [4:0]          div_reg,     div_next;
  logic                tick_reg,    tick_next;
  logic [32:0]         scr_reg,     scr_next;
  logic [2:0]          disp_reg,    disp_next;
  tpse_trip_t          trip_reg,    trip_next;
  logic                vld_reg,     vld_next;
  logic                take_reg,    take_next;

  logic [3:0]          sc;
  logic [3:0]          sd;
  logic [3:0]          dsum;
  tpse_trip_t          enc;

  function automatic logic [3:0] sym_val(input logic [1:0] s);
    sym_val = 4'h0;
    if (s == SYM_P) begin
      sym_val = 4'h1;
    end else if (s == SYM_N) begin
      sym_val = 4'hF;
    end
  endfunction

  // Net disparity of a triplet, 4-bit two's complement
  function automatic logic [3:0] trip_sum(input tpse_trip_t t);
    trip_sum = sym_val(t.a) + sym_val(t.b) + sym_val(t.c);
  endfunction

  function automatic logic [3:0] derive(input logic [32:0] s);
    derive[0] = s[0];
    derive[1] = s[3] ^ s[8];
    derive[2] = s[6] ^ s[16];
    derive[3] = s[9] ^ s[14] ^ s[19] ^ s[24];
  endfunction

  function automatic tpse_trip_t encode(input logic [3:0] n, input logic [2:0] d);
    logic d1;
    logic d4;
    logic hi;
    d1 = (d == 3'h1);
    d4 = (d == DISP_MAX);
    hi = (d >= 3'h3);
    case (n)
      4'h0: encode = d1 ? {SYM_P, SYM_Z, SYM_P} : {SYM_Z, SYM_N, SYM_Z};
      4'h1: encode = {SYM_Z, SYM_N, SYM_P};
      4'h2: encode = {SYM_P, SYM_N, SYM_Z};
      4'h3: encode = d4 ? {SYM_N, SYM_N, SYM_Z} : {SYM_Z, SYM_Z, SYM_P};
      4'h4: encode = {SYM_N, SYM_P, SYM_Z};
      4'h5: encode = d1 ? {SYM_Z, SYM_P, SYM_P} : {SYM_N, SYM_Z, SYM_Z};
      4'h6: encode = hi ? {SYM_P, SYM_N, SYM_N} : {SYM_N, SYM_P, SYM_P};
      4'h7: encode = {SYM_N, SYM_Z, SYM_P};
      4'h8: encode = d4 ? {SYM_Z, SYM_N, SYM_N} : {SYM_P, SYM_Z, SYM_Z};
      4'h9: encode = d4 ? {SYM_N, SYM_N, SYM_N} : {SYM_P, SYM_N, SYM_P};
      4'hA: encode = hi ? {SYM_N, SYM_N, SYM_P} : {SYM_P, SYM_P, SYM_N};
      4'hB: encode = {SYM_P, SYM_Z, SYM_N};
      4'hC: encode = d1 ? {SYM_P, SYM_P, SYM_P} : {SYM_N, SYM_P, SYM_N};
      4'hD: encode = d4 ? {SYM_N, SYM_Z, SYM_N} : {SYM_Z, SYM_P, SYM_Z};
      4'hE: encode = {SYM_Z, SYM_P, SYM_N};
      default: encode = d1 ? {SYM_P, SYM_P, SYM_Z} : {SYM_Z, SYM_Z, SYM_N};
    endcase
  endfunction

  function automatic tpse_trip_t dispres(input logic [2:0] d);
    case (d)
      3'h1:    dispres = {SYM_N, SYM_Z, SYM_P};
      3'h2:    dispres = {SYM_N, SYM_Z, SYM_Z};
      3'h3:    dispres = {SYM_N, SYM_Z, SYM_N};
      default: dispres = {SYM_N, SYM_N, SYM_N};
    endcase
  endfunction

  // AXI4-Lite slave
  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    ctrl_next    = ctrl_reg;
    srst_next    = 1'b0;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
      wready_next = 1'b0;
    end
    if (aw_full_reg && w_full_reg) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      if (awaddr_reg == OFF_CTRL) begin
        if (wstrb_reg[0]) begin
          ctrl_next = wdata_reg[2:0];
          srst_next = wdata_reg[CB_SRST];
        end
      end else if (awaddr_reg != OFF_STAT && awaddr_reg != OFF_SCR) begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      rdata_next   = 32'h0;
      if (s_axi_araddr == OFF_CTRL) begin
        rdata_next[2:0] = ctrl_reg;
      end else if (s_axi_araddr == OFF_STAT) begin
        rdata_next[2:0]        = disp_reg;
        rdata_next[SB_SCR_TOP] = scr_reg[TAP_TOP];
      end else if (s_axi_araddr == OFF_SCR) begin
        rdata_next = scr_reg[31:0];
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
      ctrl_reg    <= CTRL_RST;
      srst_reg    <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ctrl_reg    <= ctrl_next;
      srst_reg    <= srst_next;
    end
  end

  // Scrambled nibble and encoder
  always_comb begin
    sc = derive(scr_reg);
    if (mii_tx_en) begin
      sd = sc ^ mii_txd;
    end else begin
      sd[3] = sc[3] ^ ctrl_reg.rcvr_ok;
      sd[2] = sc[1] ^ ctrl_reg.lpi_req;
      sd[1] = sc[2];
      sd[0] = sc[0];
    end
    enc  = encode(sd, disp_reg);
    dsum = {1'b0, disp_reg} + trip_sum(trip_next);
  end

  always_comb begin
    div_next  = (div_reg == TRIP_LAST) ? 5'h0 : div_reg + 5'h1;
    tick_next = (div_reg == TRIP_LAST);
    scr_next  = scr_reg;
    disp_next = disp_reg;
    trip_next = trip_reg;
    vld_next  = 1'b0;
    take_next = 1'b0;
    if (srst_reg) begin
      div_next  = 5'h0;
      tick_next = 1'b0;
      scr_next  = SCR_SEED;
      disp_next = DISP_INIT;
    end else if (tick_reg) begin
      vld_next = 1'b1;
      if (ctrl_reg.master) begin
        scr_next = {scr_reg[31:0], scr_reg[TAP_M] ^ scr_reg[TAP_TOP]};
      end else begin
        scr_next = {scr_reg[31:0], scr_reg[TAP_S] ^ scr_reg[TAP_TOP]};
      end
      case (tx_kind)
        K_NORM: begin
          trip_next = enc;
          disp_next = dsum[2:0];
          take_next = mii_tx_en;
        end
        K_DRES: begin
          trip_next = dispres(disp_reg);
          disp_next = DISP_RES;
        end
        K_SSD4: begin
          trip_next = {SYM_P, SYM_P, SYM_N};
          disp_next = dsum[2:0];
        end
        K_ESD4: begin
          trip_next = {SYM_P, SYM_N, SYM_P};
          disp_next = dsum[2:0];
        end
        K_EERR: begin
          trip_next = {SYM_N, SYM_P, SYM_P};
          disp_next = dsum[2:0];
        end
        K_COMMA: begin
          trip_next = {SYM_Z, SYM_Z, SYM_Z};
        end
        default: begin
          trip_next = {SYM_Z, SYM_Z, SYM_Z};
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_reg  <= 5'h0;
      tick_reg <= 1'b0;
      scr_reg  <= SCR_SEED;
      disp_reg <= DISP_INIT;
      trip_reg <= {SYM_Z, SYM_Z, SYM_Z};
      vld_reg  <= 1'b0;
      take_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
      scr_reg  <= scr_next;
      disp_reg <= disp_next;
      trip_reg <= trip_next;
      vld_reg  <= vld_next;
      take_reg <= take_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign trip_out      = trip_reg;
  assign trip_valid    = vld_reg;
  assign nibble_taken  = take_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic go;
  assign go = tick_reg && !srst_reg;

  a_disp_range: assert property (disp_reg >= 3'h1 && disp_reg <= DISP_MAX)
    else $error("disparity out of range");
  a_reset_disp: assert property ($past(rst) |-> disp_reg == DISP_INIT)
    else $error("disparity not two after reset");
  a_scr_nonzero: assert property (scr_reg != 33'h0)
    else $error("scrambler state all zero");
  a_scr_shift: assert property (go |=> scr_reg[32:1] == $past(scr_reg[31:0]))
    else $error("scrambler did not shift by one");
  a_scr_hold: assert property (!tick_reg && !srst_reg |=> $stable(scr_reg))
    else $error("scrambler moved between ticks");
  a_master_fb: assert property (go && ctrl_reg.master |=>
    scr_reg[0] == ($past(scr_reg[12]) ^ $past(scr_reg[32])))
    else $error("master feedback wrong");
  a_slave_fb: assert property (go && !ctrl_reg.master |=>
    scr_reg[0] == ($past(scr_reg[19]) ^ $past(scr_reg[32])))
    else $error("slave feedback wrong");
  a_comma_zero: assert property (go && tx_kind == K_COMMA |=>
    trip_reg == {SYM_Z, SYM_Z, SYM_Z} && vld_reg)
    else $error("comma not zero triplet");
  a_sendz_zero: assert property (go && tx_kind == K_SENDZ |=>
    trip_reg == {SYM_Z, SYM_Z, SYM_Z} && $stable(disp_reg))
    else $error("send zero not zero triplet");
  a_dres_one: assert property (go && tx_kind == K_DRES |=> disp_reg == DISP_RES)
    else $error("disparity reset did not reach one");
  a_delim_two: assert property (go && tx_kind == K_DRES ##16
    go && tx_kind == K_SSD4 |=> disp_reg == DISP_INIT)
    else $error("delimiter did not restore two");
  a_norm_nonzero: assert property (go && tx_kind == K_NORM |=>
    trip_reg != {SYM_Z, SYM_Z, SYM_Z})
    else $error("mapping produced zero triplet");

  c_data: cover property (go && tx_kind == K_NORM && mii_tx_en);
  c_idle: cover property (go && tx_kind == K_NORM && !mii_tx_en);
  c_dres4: cover property (go && tx_kind == K_DRES && disp_reg == DISP_MAX);
  c_comma: cover property (go && tx_kind == K_COMMA);

endmodule

// *** tpse_mac.sv ***
// Purpose: Behavioural MAC driving the MII transmit nibble stream
// Assumes: Each nibble is held until the block reports it taken
// Notes:   Between frames the data lines toggle every cycle
`timescale 1ns/1ps
module tpse_mac (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       nibble_taken,
  output logic            tx_en,
  output logic [3:0]      txd
);
  import tpse_pkg::*;
  logic [7:0] cnt_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_en   <= 1'b0;
      txd     <= 4'h5;
      cnt_reg <= 8'h0;
    end else if (go && !tx_en) begin
      tx_en   <= 1'b1;
      txd     <= 4'h0;
      cnt_reg <= len;
    end else if (!tx_en) begin
      txd <= ~txd;
    end else if (nibble_taken) begin
      // Step of 7 walks through all 16 nibble values
      cnt_reg <= cnt_reg - 8'h1;
      txd     <= txd + 4'h7;
      tx_en   <= cnt_reg != 8'h1;
    end
  end
endmodule

// *** tb_top.sv ***
// Purpose: Self-checking bench for the ternary transmit scrambler and encoder
// Assumes: Reference scrambler and table are kept here, apart from the design
// Notes:   Triplets are checked half a cycle after each trip_valid edge
`timescale 1ns/1ps
module tb_top;
  import tpse_pkg::*;
  logic        mclk, rst, go, tx_en, trip_valid, nibble_taken;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb, txd, sc, sd;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rr;
  logic [32:0] ms;
  tpse_kind_t  kind;
  tpse_trip_t  trip_out;
  int          n_fail, total_checks, md, ctl;
  string       s;
  string       dres = "-0+-00-0----";
  string       tbl [4] = '{"+0+0-++-000+-+00++-++-0++00+-+++-+0-+++0+00+-++0",
                           "0-00-++-000+-+0-00-++-0++00+-+++-+0--+-0+00+-00-",
                           "0-00-++-000+-+0-00+---0++00+-+--++0--+-0+00+-00-",
                           "0-00-++-0--0-+0-00+---0+0-------++0--+--0-0+-00-"};

  tpse_tx uut (.mclk(mclk), .rst(rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .mii_tx_en(tx_en), .mii_txd(txd), .tx_kind(kind), .trip_out(trip_out),
    .trip_valid(trip_valid), .nibble_taken(nibble_taken));

  tpse_mac mac (.mclk(mclk), .rst(rst), .go(go), .len(8'd40),
    .nibble_taken(nibble_taken), .tx_en(tx_en), .txd(txd));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [5:0] tr(string t);
    for (int i = 0; i < 3; i++) tr[5-2*i -: 2] = t[i] == "+" ? SYM_P : t[i] == "-" ? SYM_N : SYM_Z;
  endfunction

  function automatic int sm(string t);
    sm = 0;
    for (int i = 0; i < 3; i++) sm += t[i] == "+" ? 1 : t[i] == "-" ? -1 : 0;
  endfunction

  task end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk_reg(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp=%h got=%h", nm, e, g);
    end
  endtask

  task chk_trip(string nm, logic [5:0] e, logic [5:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp=%h got=%h md=%0d", nm, e, g, md);
    end
  endtask

  task axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
    bready <= 1'b0;
  endtask

  task axr(input logic [3:0] a);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task wt(int n);
    repeat (n) do @(posedge mclk); while (!trip_valid);
  endtask

  // Reference model: scrambler state before shift, running disparity
  always @(negedge mclk) begin
    if (rst) begin
      ms = SCR_SEED;
      md = 2;
    end else if (trip_valid) begin
      sc = {ms[9] ^ ms[14] ^ ms[19] ^ ms[24], ms[6] ^ ms[16], ms[3] ^ ms[8], ms[0]};
      sd = tx_en ? sc ^ txd : {sc[3] ^ ctl[1], sc[1] ^ ctl[2], sc[2], sc[0]};
      case (kind)
        K_NORM: s = tbl[md-1].substr(3*sd, 3*sd+2);
        K_DRES: s = dres.substr(3*md-3, 3*md-1);
        K_SSD4: s = "++-";
        K_ESD4: s = "+-+";
        K_EERR: s = "-++";
        default: s = "000";
      endcase
      if (kind == K_NORM) chk_trip("enc", tr(s), trip_out);
      else chk_trip("delim", tr(s), trip_out);
      chk_reg("taken", 32'(kind == K_NORM && tx_en), 32'(nibble_taken));
      md = kind == K_DRES ? 1 : (kind == K_COMMA || kind > K_EERR) ? md : md + sm(s);
      ms = {ms[31:0], ms[32] ^ (ctl[0] ? ms[12] : ms[19])};
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_sim;
  end

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, go} = 6'h0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    kind = K_NORM;
    n_fail = 0;
    total_checks = 0;
    ctl = 1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    axr(OFF_STAT);
    chk_reg("stat", {23'h0, SCR_SEED[32], 5'h0, DISP_INIT}, rd);
    axr(OFF_SCR);
    chk_reg("scr", SCR_SEED[31:0], rd);
    axr(OFF_CTRL);
    chk_reg("ctrl", 32'h1, rd);
    axr(4'hC);
    chk_reg("rresp", 32'(RESP_SLVERR), 32'(rr));
    axw(4'hC, 32'h0);
    chk_reg("bresp", 32'(RESP_SLVERR), 32'(rr));
    for (int c = 0; c < 8; c++) begin
      wt(1);
      axw(OFF_CTRL, 32'(c));
      ctl = c;
      wt(3);
    end
    for (int i = 0; i < 2; i++) begin
      wt(1);
      axw(OFF_CTRL, i == 0 ? 32'h6 : 32'h3);
      ctl = i == 0 ? 6 : 3;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      wt(44);
    end
    // Fourth groups only follow a disparity reset, keeping disparity in 1..4
    for (int k = 1; k < 8; k++) begin
      wt(1);
      if (k >= 3 && k <= 5) begin
        kind <= K_DRES;
        wt(1);
        kind <= tpse_kind_t'(k);
        wt(1);
      end else begin
        kind <= tpse_kind_t'(k);
        wt(2);
      end
      kind <= K_NORM;
    end
    wt(1);
    kind <= K_DRES;
    wt(1);
    kind <= K_SSD4;
    wt(1);
    kind <= K_NORM;
    axr(OFF_STAT);
    chk_reg("disp", 32'(DISP_INIT), 32'(rd[2:0]));
    wt(1);
    axw(OFF_CTRL, 32'h9);
    ms = SCR_SEED;
    md = 2;
    ctl = 1;
    repeat (2) @(posedge mclk);
    axr(OFF_SCR);
    chk_reg("srst", SCR_SEED[31:0], rd);
    wt(4);
    end_sim;
  end
endmodule
